// ---- inc/operand_addr_defs.svh ----
// constants for the operand addressing block of the 8-bit core
// assumes the core fetches opcode and operands and pre-decodes the opcode
// Overview of operation
// - Source immediate takes operand 1 as the value, writes A, F, SP or X per opcode, length two.
// - An immediate AND aimed at the flags combines the byte with the flags and stores it there.
// - Source direct reads the byte at operand 1, writes A or X, length two.
// - Arithmetic in source direct or indexed uses the named A or X as first operand.
// - Source indexed reads at operand 1 plus X, writes A or X, length two.
// - Destination direct writes the byte at operand 1 from A or X, length two.
// - Arithmetic with a direct destination first reads that location as its first operand.
// - A store from A into memory leaves A unchanged.
// - Destination indexed writes at operand 1 plus X from A, reading it first for arithmetic.
// - Destination indexed takes only A as the register source, never X.
// - Destination direct with immediate writes at operand 1 the operand 2 value, length three.
// - Destination indexed with immediate writes at operand 1 plus X, length three.
// - Direct to direct copies the RAM byte at operand 2 to RAM at operand 1, length three.
// - Direct to direct is accepted for the move only and refused otherwise.
// - Source indirect reads a pointer at operand 1 and loads its target into A, length two.
// - Source indirect increments the stored pointer and exists only on the indirect move.
`ifndef OPERAND_ADDR_DEFS_SVH
`define OPERAND_ADDR_DEFS_SVH

// ****************************************
// widths and values
// ****************************************
`define OA_LEN_TWO      2'h2
`define OA_LEN_THREE    2'h3
`define OA_LEN_NONE     2'h0
`define OA_BYTE_ZERO    8'h00
`define OA_FLAGS_RESET  8'h02
`define OA_PTR_STEP     8'h01
`define OA_FLAG_CARRY   2
`define OA_SPACE_RAM    1'b0
`define OA_SPACE_REG    1'b1

`endif

// ---- inc/operand_addr_pkg.sv ----
// types for the operand addressing block
// assumes the opcode pre-decoder drives these codes
package operand_addr_pkg;

  // ****************************************
  // addressing modes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_SRC_IMM,
    MODE_SRC_DIR,
    MODE_SRC_IDX,
    MODE_DST_DIR,
    MODE_DST_IDX,
    MODE_DST_DIR_IMM,
    MODE_DST_IDX_IMM,
    MODE_DIR_DIR,
    MODE_SRC_IND_INC
  } addr_mode_e;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [2:0] {
    OP_MOV,
    OP_ADD,
    OP_ADC,
    OP_SUB,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_INDIRECT_MOVE_INSTR
  } alu_op_e;

  typedef enum logic [1:0] {
    SEL_A,
    SEL_X,
    SEL_F,
    SEL_SP
  } reg_sel_e;

endpackage

// ---- logic/operand_alu.sv ----
// byte alu used by the operand addressing sequencer
// assumes combinational use; flag updates are done elsewhere
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module operand_alu (
  // operation
  input  wire operand_addr_pkg::alu_op_e op_i,
  input  wire logic                      carry_i,
  // operands
  input  wire logic [7:0]                a_i,
  input  wire logic [7:0]                b_i,
  // result
  output logic      [7:0]                result_o
);
  import operand_addr_pkg::*;

  always_comb begin
    unique case (op_i)
      OP_ADD:  result_o = a_i + b_i;
      OP_ADC:  result_o = a_i + b_i + {7'h00, carry_i};
      OP_SUB:  result_o = a_i - b_i;
      OP_AND:  result_o = a_i & b_i;
      OP_OR:   result_o = a_i | b_i;
      OP_XOR:  result_o = a_i ^ b_i;
      // moves pass the source straight through
      default: result_o = b_i;
    endcase
  end
endmodule

// ---- logic/operand_addressing.sv ----
// operand addressing sequencer: forms addresses, reads, computes, writes back
// assumes synchronous-read RAM and register space, data valid one cycle after rd
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module operand_addressing (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // decoded instruction
  input  wire logic                        start_i,
  input  wire operand_addr_pkg::addr_mode_e mode_i,
  input  wire operand_addr_pkg::alu_op_e   op_i,
  input  wire operand_addr_pkg::reg_sel_e  reg_sel_i,
  input  wire logic                        space_i,
  input  wire logic [7:0]                  op1_i,
  input  wire logic [7:0]                  op2_i,
  // ram port
  output logic      [7:0]                  ram_addr_o,
  output logic                             ram_rd_o,
  output logic                             ram_wr_o,
  output logic      [7:0]                  ram_wdata_o,
  input  wire logic [7:0]                  ram_rdata_i,
  // register space port
  output logic      [7:0]                  reg_addr_o,
  output logic                             reg_rd_o,
  output logic                             reg_wr_o,
  output logic      [7:0]                  reg_wdata_o,
  input  wire logic [7:0]                  reg_rdata_i,
  // core registers
  output logic      [7:0]                  a_o,
  output logic      [7:0]                  x_o,
  output logic      [7:0]                  f_o,
  output logic      [7:0]                  sp_o,
  // status
  output logic                             busy_o,
  output logic                             done_o,
  output logic                             illegal_o,
  output logic      [1:0]                  length_o
);
  import operand_addr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD1,
    ST_USE1,
    ST_RD2,
    ST_USE2,
    ST_WR
  } seq_state_e;

  seq_state_e state_reg, state_next;
  addr_mode_e mode_reg, mode_next;
  alu_op_e    op_reg, op_next;
  reg_sel_e   sel_reg, sel_next;
  logic       space_reg, space_next;
  logic [7:0] op1_reg, op1_next;
  logic [7:0] op2_reg, op2_next;
  logic [7:0] ea_reg, ea_next;
  logic [7:0] a_reg, a_next, x_reg, x_next, f_reg, f_next, sp_reg, sp_next;
  logic [7:0] mem_addr_reg, mem_addr_next, wdata_reg, wdata_next;
  logic       rd_next, wr_next, bus_space_reg, bus_space_next;
  logic       ram_rd_reg, ram_rd_next, ram_wr_reg, ram_wr_next;
  logic       reg_rd_reg, reg_rd_next, reg_wr_reg, reg_wr_next;
  logic       busy_reg, busy_next, done_reg, done_next, illegal_reg, illegal_next;
  logic [1:0] length_reg, length_next;

  // ****************************************
  // decode helpers
  // ****************************************
  logic       arith;
  logic       bad;
  logic       need_read;
  logic [7:0] fetched;
  logic [7:0] cur_reg;
  logic [7:0] alu_a, alu_b, alu_res;

  assign arith   = (op_reg != OP_MOV) && (op_reg != OP_INDIRECT_MOVE_INSTR);
  // separate spaces, chosen by the access space
  assign fetched = (bus_space_reg == `OA_SPACE_REG) ? reg_rdata_i : ram_rdata_i;

  // move only; indirect move only
  // only immediate sources may aim at the flags or stack pointer
  assign bad = (mode_i == MODE_DIR_DIR && op_i != OP_MOV)
               || ((mode_i == MODE_SRC_IND_INC) != (op_i == OP_INDIRECT_MOVE_INSTR))
               || (mode_i != MODE_SRC_IMM && (reg_sel_i == SEL_F || reg_sel_i == SEL_SP));

  always_comb begin
    unique case (mode_i)
      MODE_SRC_DIR, MODE_SRC_IDX, MODE_DIR_DIR, MODE_SRC_IND_INC: need_read = 1'b1;
      MODE_DST_DIR, MODE_DST_IDX, MODE_DST_DIR_IMM, MODE_DST_IDX_IMM:
        need_read = (op_i != OP_MOV);
      default: need_read = 1'b0;
    endcase
  end

  always_comb begin
    unique case (sel_reg)
      SEL_A:  cur_reg = a_reg;
      SEL_X:  cur_reg = x_reg;
      SEL_F:  cur_reg = f_reg;
      SEL_SP: cur_reg = sp_reg;
    endcase
  end

  // ****************************************
  // alu operand routing
  // ****************************************
  always_comb begin
    alu_a = cur_reg;
    alu_b = op1_reg;
    unique case (mode_reg)
      MODE_SRC_IMM: begin
        alu_b = op1_reg;
      end
      MODE_SRC_DIR, MODE_SRC_IDX: begin
        alu_b = fetched;
      end
      MODE_DST_DIR: begin
        alu_a = fetched;
        alu_b = cur_reg;
      end
      MODE_DST_IDX: begin
        alu_a = fetched;
        alu_b = a_reg;
      end
      MODE_DST_DIR_IMM, MODE_DST_IDX_IMM: begin
        alu_a = fetched;
        alu_b = op2_reg;
      end
      default: begin
        alu_a = cur_reg;
        alu_b = fetched;
      end
    endcase
  end

  operand_alu operand_alu_inst (
    .op_i     (op_reg),
    .carry_i  (f_reg[`OA_FLAG_CARRY]),
    .a_i      (alu_a),
    .b_i      (alu_b),
    .result_o (alu_res)
  );

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    state_next     = state_reg;
    mode_next      = mode_reg;
    op_next        = op_reg;
    sel_next       = sel_reg;
    space_next     = space_reg;
    op1_next       = op1_reg;
    op2_next       = op2_reg;
    ea_next        = ea_reg;
    a_next         = a_reg;
    x_next         = x_reg;
    f_next         = f_reg;
    sp_next        = sp_reg;
    mem_addr_next  = mem_addr_reg;
    wdata_next     = wdata_reg;
    bus_space_next = bus_space_reg;
    rd_next        = 1'b0;
    wr_next        = 1'b0;
    done_next      = 1'b0;
    illegal_next   = illegal_reg;
    length_next    = length_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_i) begin
          mode_next    = mode_i;
          op_next      = op_i;
          sel_next     = reg_sel_i;
          space_next   = space_i;
          op1_next     = op1_i;
          op2_next     = op2_i;
          illegal_next = bad;
          if (mode_i == MODE_SRC_IDX || mode_i == MODE_DST_IDX
              || mode_i == MODE_DST_IDX_IMM) begin
            ea_next = op1_i + x_reg;
          end else begin
            ea_next = op1_i;
          end
          if (mode_i == MODE_DST_DIR_IMM || mode_i == MODE_DST_IDX_IMM
              || mode_i == MODE_DIR_DIR) begin
            length_next = `OA_LEN_THREE;
          end else begin
            length_next = `OA_LEN_TWO;
          end
          if (bad) begin
            length_next = `OA_LEN_NONE;
            done_next   = 1'b1;
          end else if (need_read) begin
            rd_next    = 1'b1;
            state_next = ST_RD1;
            bus_space_next = space_i;
            mem_addr_next  = ea_next;
            if (mode_i == MODE_DIR_DIR) begin
              bus_space_next = `OA_SPACE_RAM;
              mem_addr_next  = op2_i;
            end
            if (mode_i == MODE_SRC_IND_INC) begin
              bus_space_next = `OA_SPACE_RAM;
            end
          end else begin
            state_next = ST_USE1;
          end
        end
      end
      ST_RD1: begin
        state_next = ST_USE1;
      end
      ST_USE1: begin
        unique case (mode_reg)
          MODE_SRC_IMM, MODE_SRC_DIR, MODE_SRC_IDX: begin
            unique case (sel_reg)
              SEL_A:  a_next  = alu_res;
              SEL_X:  x_next  = alu_res;
              SEL_F:  f_next  = alu_res;
              SEL_SP: sp_next = alu_res;
            endcase
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
          MODE_SRC_IND_INC: begin
            op2_next      = fetched;
            mem_addr_next = fetched;
            rd_next       = 1'b1;
            state_next    = ST_RD2;
          end
          default: begin
            bus_space_next = (mode_reg == MODE_DIR_DIR) ? `OA_SPACE_RAM : space_reg;
            mem_addr_next  = ea_reg;
            if (mode_reg == MODE_DIR_DIR) begin
              wdata_next = fetched;
            end else begin
              wdata_next = arith ? alu_res : alu_b;
            end
            wr_next    = 1'b1;
            state_next = ST_WR;
          end
        endcase
      end
      ST_RD2: begin
        state_next = ST_USE2;
      end
      ST_USE2: begin
        a_next        = ram_rdata_i;
        mem_addr_next = op1_reg;
        wdata_next    = op2_reg + `OA_PTR_STEP;
        wr_next       = 1'b1;
        state_next    = ST_WR;
      end
      ST_WR: begin
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    busy_next = (state_next != ST_IDLE);
    // strobes split per space so a register access never touches ram
    ram_rd_next = rd_next & (bus_space_next == `OA_SPACE_RAM);
    ram_wr_next = wr_next & (bus_space_next == `OA_SPACE_RAM);
    reg_rd_next = rd_next & (bus_space_next == `OA_SPACE_REG);
    reg_wr_next = wr_next & (bus_space_next == `OA_SPACE_REG);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg     <= ST_IDLE;
      mode_reg      <= MODE_SRC_IMM;
      op_reg        <= OP_MOV;
      sel_reg       <= SEL_A;
      space_reg     <= `OA_SPACE_RAM;
      op1_reg       <= `OA_BYTE_ZERO;
      op2_reg       <= `OA_BYTE_ZERO;
      ea_reg        <= `OA_BYTE_ZERO;
      a_reg         <= `OA_BYTE_ZERO;
      x_reg         <= `OA_BYTE_ZERO;
      f_reg         <= `OA_FLAGS_RESET;
      sp_reg        <= `OA_BYTE_ZERO;
      mem_addr_reg  <= `OA_BYTE_ZERO;
      wdata_reg     <= `OA_BYTE_ZERO;
      bus_space_reg <= `OA_SPACE_RAM;
      ram_rd_reg    <= 1'b0;
      ram_wr_reg    <= 1'b0;
      reg_rd_reg    <= 1'b0;
      reg_wr_reg    <= 1'b0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
      length_reg    <= `OA_LEN_NONE;
    end else begin
      state_reg     <= state_next;
      mode_reg      <= mode_next;
      op_reg        <= op_next;
      sel_reg       <= sel_next;
      space_reg     <= space_next;
      op1_reg       <= op1_next;
      op2_reg       <= op2_next;
      ea_reg        <= ea_next;
      a_reg         <= a_next;
      x_reg         <= x_next;
      f_reg         <= f_next;
      sp_reg        <= sp_next;
      mem_addr_reg  <= mem_addr_next;
      wdata_reg     <= wdata_next;
      bus_space_reg <= bus_space_next;
      ram_rd_reg    <= ram_rd_next;
      ram_wr_reg    <= ram_wr_next;
      reg_rd_reg    <= reg_rd_next;
      reg_wr_reg    <= reg_wr_next;
      busy_reg      <= busy_next;
      done_reg      <= done_next;
      illegal_reg   <= illegal_next;
      length_reg    <= length_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // distinct spaces
  assign ram_addr_o  = mem_addr_reg;
  assign ram_wdata_o = wdata_reg;
  assign ram_rd_o    = ram_rd_reg;
  assign ram_wr_o    = ram_wr_reg;
  assign reg_addr_o  = mem_addr_reg;
  assign reg_wdata_o = wdata_reg;
  assign reg_rd_o    = reg_rd_reg;
  assign reg_wr_o    = reg_wr_reg;
  assign a_o         = a_reg;
  assign x_o         = x_reg;
  assign f_o         = f_reg;
  assign sp_o        = sp_reg;
  assign busy_o      = busy_reg;
  assign done_o      = done_reg;
  assign illegal_o   = illegal_reg;
  assign length_o    = length_reg;
endmodule

// ---- tb/operand_addressing_checker.sv ----
// assertions for the operand addressing sequencer
// assumes binding to the sequencer, sees its ports only
`timescale 1ns/1ps
module operand_addressing_checker
  import operand_addr_pkg::*;
(
  // clock and reset
  input wire logic                         clk_i,
  input wire logic                         reset_n_i,
  // request
  input wire logic                         start_i,
  input wire operand_addr_pkg::addr_mode_e mode_i,
  input wire operand_addr_pkg::alu_op_e    op_i,
  input wire operand_addr_pkg::reg_sel_e   reg_sel_i,
  input wire logic                         space_i,
  input wire logic [7:0]                   op1_i,
  input wire logic [7:0]                   op2_i,
  // accesses and status
  input wire logic [7:0]                   ram_addr_o,
  input wire logic                         ram_rd_o,
  input wire logic                         ram_wr_o,
  input wire logic [7:0]                   reg_addr_o,
  input wire logic                         reg_rd_o,
  input wire logic                         reg_wr_o,
  input wire logic [7:0]                   a_o,
  input wire logic [7:0]                   x_o,
  input wire logic                         busy_o,
  input wire logic                         done_o,
  input wire logic                         illegal_o,
  input wire logic [1:0]                   length_o
);
  logic       acc;
  logic       ok;
  logic       rd_any;
  logic       wr_any;
  logic [7:0] idx_sum;

  always_comb begin
    acc = start_i && !busy_o;
    ok = !((mode_i == MODE_DIR_DIR && op_i != OP_MOV) || (reg_sel_i > SEL_X && mode_i != MODE_SRC_IMM)
         || ((mode_i == MODE_SRC_IND_INC) != (op_i == OP_INDIRECT_MOVE_INSTR)));
    rd_any = ram_rd_o || reg_rd_o;
    wr_any = ram_wr_o || reg_wr_o;
    idx_sum = op1_i + x_o;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ****************************************
  // assertions
  // ****************************************
  a_imm_two_cycles:
    assert property (acc && ok && mode_i == MODE_SRC_IMM |-> ##2 done_o && length_o == 2'h2)
    else $error("source immediate timing or length wrong");
  a_refused_quiet:
    assert property (acc && !ok |=> done_o && illegal_o && length_o == 2'h0 && !rd_any && !wr_any)
    else $error("refused request not handled quietly");
  a_src_dir_space:
    assert property (acc && ok && mode_i == MODE_SRC_DIR |=> $past(space_i) ?
      (reg_rd_o && !ram_rd_o && reg_addr_o == $past(op1_i)) :
      (ram_rd_o && !reg_rd_o && ram_addr_o == $past(op1_i)))
    else $error("source direct read wrong");
  a_src_idx_addr:
    assert property (acc && ok && mode_i == MODE_SRC_IDX |=>
      rd_any && (ram_rd_o ? ram_addr_o : reg_addr_o) == $past(idx_sum))
    else $error("source indexed address wrong");
  a_dst_arith_rmw:
    assert property (acc && ok && mode_i inside {MODE_DST_DIR, MODE_DST_IDX} && op_i != OP_MOV
      |=> rd_any ##2 wr_any ##1 done_o)
    else $error("destination arithmetic sequence wrong");
  a_dst_mov_write:
    assert property (acc && ok && mode_i == MODE_DST_DIR && op_i == OP_MOV
      |=> !rd_any && !wr_any ##1 wr_any ##1 done_o && length_o == 2'h2)
    else $error("destination move sequence wrong");
  a_dst_imm_len:
    assert property (acc && ok && mode_i inside {MODE_DST_DIR_IMM, MODE_DST_IDX_IMM}
      |-> ##[3:4] done_o && length_o == 2'h3)
    else $error("immediate destination length wrong");
  a_dir_dir_copy:
    assert property (acc && ok && mode_i == MODE_DIR_DIR |=> ram_rd_o && ram_addr_o == $past(op2_i)
      ##2 ram_wr_o && ram_addr_o == $past(op1_i, 3) ##1 done_o && length_o == 2'h3)
    else $error("direct to direct copy wrong");
  a_ind_inc_seq:
    assert property (acc && ok && mode_i == MODE_SRC_IND_INC |=> ram_rd_o && ram_addr_o == $past(op1_i)
      ##2 ram_rd_o ##2 ram_wr_o && ram_addr_o == $past(op1_i, 5) ##1 done_o)
    else $error("indirect sequence wrong");
  a_acc_kept:
    assert property (acc && ok && mode_i inside {[MODE_DST_DIR:MODE_DST_IDX_IMM]} |=> $stable(a_o) [*4])
    else $error("accumulator changed by memory store");

  c_refused: cover property (acc && !ok);
  c_dir_dir: cover property (acc && ok && mode_i == MODE_DIR_DIR);
  c_ind_inc: cover property (acc && ok && mode_i == MODE_SRC_IND_INC);
endmodule
bind operand_addressing operand_addressing_checker operand_addressing_checker_inst (.*);

// ---- tb/tb_cpu_operand_addressing.sv ----
// self-checking bench for the operand addressing sequencer
// assumes the bench stands in for ram and register space
`timescale 1ns/1ps
module tb_cpu_operand_addressing;
  import operand_addr_pkg::*;
  logic       clk_i, reset_n_i, start_i, space_i;
  addr_mode_e mode_i;
  alu_op_e    op_i;
  reg_sel_e   reg_sel_i;
  logic [7:0] op1_i, op2_i, ram_addr_o, ram_wdata_o, ram_rdata_i, reg_addr_o, reg_wdata_o;
  logic [7:0] reg_rdata_i, a_o, x_o, f_o, sp_o, ram_la, reg_la, lfsr, ea, ex, ef, esp;
  logic       ram_rd_o, ram_wr_o, reg_rd_o, reg_wr_o, busy_o, done_o, illegal_o, ram_rv, reg_rv;
  logic [1:0] length_o;
  logic [7:0] ram [256];
  logic [7:0] rgs [256];
  int         n_errors, checked;

  operand_addressing operand_addressing_inst (.*);

  // ****************************************
  // memories: data valid in the read cycle and the cycle after it
  // ****************************************
  always @(posedge clk_i) begin
    ram_rv <= ram_rd_o;
    reg_rv <= reg_rd_o;
    if (ram_rd_o === 1'b1) ram_la <= ram_addr_o;
    if (reg_rd_o === 1'b1) reg_la <= reg_addr_o;
    if (ram_wr_o === 1'b1) ram[ram_addr_o] <= ram_wdata_o;
    if (reg_wr_o === 1'b1) rgs[reg_addr_o] <= reg_wdata_o;
  end
  // stale data is inverted so a late sample cannot pass
  assign ram_rdata_i = ram_rd_o ? ram[ram_addr_o] : (ram_rv ? ram[ram_la] : ~ram[ram_la]);
  assign reg_rdata_i = reg_rd_o ? rgs[reg_addr_o] : (reg_rv ? rgs[reg_la] : ~rgs[reg_la]);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] nr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] alu(input alu_op_e o, input logic [7:0] p, input logic [7:0] q,
                                     input logic c);
    case (o)
      OP_ADD: return p + q;
      OP_ADC: return p + q + {7'h0, c};
      OP_SUB: return p - q;
      OP_AND: return p & q;
      OP_OR: return p | q;
      OP_XOR: return p ^ q;
      default: return q;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one instruction, started at the current falling edge
  task automatic run(input addr_mode_e m, input alu_op_e o, input reg_sel_e s, input logic sp,
                     input logic [7:0] p1, input logic [7:0] p2);
    logic [7:0] wa, rv, mv, ev, ov;
    logic       bad, es;
    logic [1:0] len;
    int         n;
    bad = (m == MODE_DIR_DIR && o != OP_MOV) || (s > SEL_X && m != MODE_SRC_IMM)
          || ((m == MODE_SRC_IND_INC) != (o == OP_INDIRECT_MOVE_INSTR));
    es = sp && !(m inside {MODE_DIR_DIR, MODE_SRC_IND_INC});
    rv = s == SEL_X ? ex : s == SEL_F ? ef : s == SEL_SP ? esp : ea;
    wa = m inside {MODE_SRC_IDX, MODE_DST_IDX, MODE_DST_IDX_IMM} ? p1 + ex : p1;
    mv = es ? rgs[wa] : ram[wa];
    ov = es ? ram[wa] : rgs[wa];
    len = bad ? 2'h0 : m inside {MODE_DST_DIR_IMM, MODE_DST_IDX_IMM, MODE_DIR_DIR} ? 2'h3 : 2'h2;
    case (m)
      MODE_SRC_IMM, MODE_SRC_DIR, MODE_SRC_IDX: ev = alu(o, rv, m == MODE_SRC_IMM ? p1 : mv, ef[2]);
      MODE_DST_DIR, MODE_DST_IDX: ev = alu(o, mv, m == MODE_DST_IDX ? ea : rv, ef[2]);
      MODE_DIR_DIR: ev = ram[p2];
      MODE_SRC_IND_INC: ev = ram[p1] + 8'h01;
      default: ev = alu(o, mv, p2, ef[2]);
    endcase
    if (!bad && m <= MODE_SRC_IDX) begin
      case (s)
        SEL_A: ea = ev;
        SEL_X: ex = ev;
        SEL_F: ef = ev;
        default: esp = ev;
      endcase
    end
    if (!bad && m == MODE_SRC_IND_INC) ea = ram[ram[p1]];
    start_i = 1'b1;
    mode_i = m;
    op_i = o;
    reg_sel_i = s;
    space_i = sp;
    op1_i = p1;
    op2_i = p2;
    @(negedge clk_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1) begin
      check({7'h0, busy_o}, 8'h01);
      if (n == 12) begin
        n_errors++;
        $display("ERROR %0t no completion", $time);
        end_of_test();
      end
      @(negedge clk_i);
      n++;
    end
    check({7'h0, illegal_o}, {7'h0, bad});
    check({6'h0, length_o}, {6'h0, len});
    check(a_o, ea);
    check(x_o, ex);
    check(f_o, ef);
    check(sp_o, esp);
    if (!bad && m > MODE_SRC_IDX) check(es ? rgs[wa] : ram[wa], ev);
    check(es ? ram[wa] : rgs[wa], ov);
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    logic [7:0] r1, r2, r3;
    addr_mode_e m;
    reset_n_i = 1'b0;
    start_i = 1'b0;
    mode_i = MODE_SRC_IMM;
    op_i = OP_MOV;
    reg_sel_i = SEL_A;
    space_i = 1'b0;
    op1_i = 8'h00;
    op2_i = 8'h00;
    n_errors = 0;
    checked = 0;
    lfsr = 8'h43;
    ea = 8'h00;
    ex = 8'h00;
    ef = 8'h02;
    esp = 8'h00;
    for (int i = 0; i < 256; i++) begin
      lfsr = nr(lfsr);
      ram[i] = lfsr;
      rgs[i] = ~lfsr;
    end
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    // flags and stack pointer immediates, carry into adc
    run(MODE_SRC_IMM, OP_ADD, SEL_A, 1'b0, 8'h07, 8'h00);
    run(MODE_SRC_IMM, OP_AND, SEL_F, 1'b0, 8'h09, 8'h00);
    run(MODE_SRC_IMM, OP_OR, SEL_F, 1'b0, 8'h04, 8'h00);
    run(MODE_SRC_IMM, OP_ADC, SEL_A, 1'b0, 8'h11, 8'h00);
    run(MODE_SRC_IMM, OP_ADD, SEL_SP, 1'b0, 8'h05, 8'h00);
    // index wraps past the top of the space
    run(MODE_SRC_IMM, OP_MOV, SEL_X, 1'b0, 8'hF0, 8'h00);
    run(MODE_SRC_IDX, OP_ADD, SEL_A, 1'b1, 8'h20, 8'h00);
    run(MODE_DST_IDX, OP_SUB, SEL_X, 1'b0, 8'h30, 8'h00);
    // pointer at the top wraps to zero
    ram[8'h08] = 8'hFF;
    run(MODE_SRC_IND_INC, OP_INDIRECT_MOVE_INSTR, SEL_A, 1'b1, 8'h08, 8'h00);
    for (int i = 0; i < 9; i++) begin
      run(addr_mode_e'(4'(i)), OP_INDIRECT_MOVE_INSTR, SEL_A, 1'b0, 8'h10, 8'h11);
      run(addr_mode_e'(4'(i)), OP_MOV, SEL_SP, 1'b1, 8'h12, 8'h13);
      if (i < 7) run(MODE_DIR_DIR, alu_op_e'(3'(i)), SEL_A, 1'b0, 8'h14, 8'h15);
      if (i < 7) run(MODE_SRC_IND_INC, alu_op_e'(3'(i)), SEL_A, 1'b0, 8'h16, 8'h17);
    end
    repeat (300) begin
      lfsr = nr(lfsr);
      r1 = lfsr;
      lfsr = nr(lfsr);
      r2 = lfsr;
      lfsr = nr(lfsr);
      r3 = lfsr;
      m = addr_mode_e'(r1[3:0] % 4'h9);
      run(m, m == MODE_DIR_DIR ? OP_MOV : m == MODE_SRC_IND_INC ? OP_INDIRECT_MOVE_INSTR :
          alu_op_e'(r2[2:0] % 3'h7), reg_sel_e'({1'b0, r2[3]}), r2[4], r3, r1);
    end
    // reset in mid-instruction drops it during its read cycle, before the write
    start_i = 1'b1;
    mode_i = MODE_DST_DIR;
    op_i = OP_ADD;
    @(negedge clk_i);
    start_i = 1'b0;
    reset_n_i = 1'b0;
    @(negedge clk_i);
    check(a_o, 8'h00);
    check(f_o, 8'h02);
    check({4'h0, busy_o, done_o, length_o}, 8'h00);
    ea = 8'h00;
    ex = 8'h00;
    ef = 8'h02;
    esp = 8'h00;
    reset_n_i = 1'b1;
    run(MODE_SRC_IMM, OP_ADC, SEL_A, 1'b0, 8'h21, 8'h00);
    end_of_test();
  end
endmodule
